// >>> core/txpm_pkg.sv
package txpm_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [6:0] STATUS_ADDR    = 7'h01;
   localparam logic [6:0] CFG0_ADDR      = 7'h04;
   localparam logic [6:0] CFG1_ADDR      = 7'h05;
   localparam int         STBY_REQ_BIT   = 7;
   localparam int         FS_DIS_BIT     = 4;
   localparam int         SLEEP_REQ_BIT  = 7;
   localparam int         ST_ONE_BIT     = 7;
   localparam int         ST_LB2_BIT     = 5;
   localparam int         ST_LB1_BIT     = 4;
   localparam int         ST_BROWN_BIT   = 2;
   localparam int         ST_PAR_BIT     = 1;
   localparam int         ST_LOCK_BIT    = 0;
   localparam logic [7:0] CFG0_RESET     = 8'h06;
   localparam logic [7:0] CFG1_RESET     = 8'h25;
   // ****************************************
   // Transmit command: top two bits set
   // ****************************************
   localparam logic [1:0] TX_CMD_MARK    = 2'h3;
   localparam int         TX_PA_MODE_BIT = 4;
   // ****************************************
   // Timing
   // ****************************************
   localparam int         TIMEOUT_CYC    = 65536;
   localparam int         SLEEP_LAT_CYC  = 2;
   localparam int         WAKE_PULSES    = 3;
   // ****************************************
   // Host AXI4-Lite map
   // ****************************************
   localparam logic [3:0] H_CMD_OFS      = 4'h0;
   localparam logic [3:0] H_STAT_OFS     = 4'h4;
   localparam logic [3:0] H_RDATA_OFS    = 4'h8;
   localparam logic [1:0] AXI_OKAY       = 2'h0;
   localparam logic [1:0] AXI_SLVERR     = 2'h2;

   typedef enum logic [2:0] {
      MODE_SLEEP, MODE_STANDBY, MODE_OSC, MODE_PLL, MODE_TX
   } mode_t;

   function automatic logic par8(input logic [7:0] d);
      return ^d;
   endfunction
endpackage

// >>> core/txpm_if.sv
`timescale 1ns/1ps
interface txpm_if;
   logic en;
   logic sclk;
   logic sdio_h;
   logic sdio_h_oe;
   logic sdio_d;
   logic sdio_d_oe;
   wire  sdio = sdio_h_oe ? sdio_h : (sdio_d_oe ? sdio_d : 1'b0);
   modport dev  (input en, sclk, sdio, output sdio_d, sdio_d_oe);
   modport host (output en, sclk, sdio_h, sdio_h_oe, input sdio);
endinterface

// >>> core/tx_power_mode_failsafe_ctrl.sv
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
// Functional notes
// - Sleep loses all configuration register contents
// - Wake needs enable high, three clock pulses
// - Sleep request then enable low, two cycles
// - Sleep request bit clears on wake
// - Enable low long enough enters standby
// - Standby request then enable low
// - Standby request bit self clears
// - Standby keeps registers, access and parity
// - Transmit ends at enable fall or time-out
// - Enable rise from standby starts oscillator
// - Oscillator state exits on requests, command or time-out
// - Transmit passes through PLL state first
// - Brownout resets core, sets flag
// - Per-register parity checked continuously
// - Lock loss while transmitting sets flag
// - Error flags cleared only by status read
// - Armed fail-safe turns amplifier off
// - Host reads status before and after
// - Two low battery thresholds, stepwise
// - Battery flags clear at transmission start
// - Status layout: one, battery, errors
// - Battery flags invalid in standby
// - Latched data held until time-out
module tx_power_mode_failsafe_ctrl
   import txpm_pkg::*;
#(
   parameter int TIMEOUT = TIMEOUT_CYC
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   // Link
   txpm_if.dev       lnk,
   // Analog status
   input  wire logic brownout_in,
   input  wire logic batt_below_first,
   input  wire logic batt_below_second,
   input  wire logic pll_locked,
   // Observed state
   output mode_t     mode,
   output logic      pa_on,
   output logic      pll_on,
   output logic      osc_on,
   output logic      tx_data,
   output logic      core_rst
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [1:0] en_s_r, sck_s_r, sd_s_r, bo_s_r, b1_s_r, b2_s_r, lk_s_r;
   logic       en_d_r, sck_d_r;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         en_s_r  <= 2'h0;
         sck_s_r <= 2'h0;
         sd_s_r  <= 2'h0;
         bo_s_r  <= 2'h0;
         b1_s_r  <= 2'h0;
         b2_s_r  <= 2'h0;
         lk_s_r  <= 2'h0;
         en_d_r  <= 1'b0;
         sck_d_r <= 1'b0;
      end else begin
         en_s_r  <= {en_s_r[0], lnk.en};
         sck_s_r <= {sck_s_r[0], lnk.sclk};
         sd_s_r  <= {sd_s_r[0], lnk.sdio};
         bo_s_r  <= {bo_s_r[0], brownout_in};
         b1_s_r  <= {b1_s_r[0], batt_below_first};
         b2_s_r  <= {b2_s_r[0], batt_below_second};
         lk_s_r  <= {lk_s_r[0], pll_locked};
         en_d_r  <= en_s_r[1];
         sck_d_r <= sck_s_r[1];
      end
   end
   logic en, en_rise, en_fall, sck_rise, sck_fall;
   assign en       = en_s_r[1];
   assign en_rise  = en & ~en_d_r;
   assign en_fall  = ~en & en_d_r;
   assign sck_rise = sck_s_r[1] & ~sck_d_r;
   assign sck_fall = ~sck_s_r[1] & sck_d_r;

   // ****************************************
   // Serial frame: 8-bit cmd/addr, 8-bit data
   // ****************************************
   logic [4:0] bit_cnt_r;
   logic [7:0] sh_r, cmd_r, rd_r;
   logic       wr_stb, rd_stb, tx_cmd;
   assign tx_cmd = en & sck_rise & (bit_cnt_r == 5'd7)
                   & (sh_r[6:5] == TX_CMD_MARK);
   assign wr_stb = en & sck_rise & (bit_cnt_r == 5'd15) & ~cmd_r[7];
   assign rd_stb = en & sck_rise & (bit_cnt_r == 5'd7)
                   & sh_r[6] & ~sh_r[5];
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bit_cnt_r <= 5'h0;
         sh_r      <= 8'h0;
         cmd_r     <= 8'h0;
      end else if (!en) begin
         bit_cnt_r <= 5'h0;
      end else if (sck_rise) begin
         sh_r      <= {sh_r[6:0], sd_s_r[1]};
         bit_cnt_r <= (bit_cnt_r == 5'd15) ? 5'h0 : bit_cnt_r + 5'd1;
         if (bit_cnt_r == 5'd7)
            cmd_r <= {sh_r[6:0], sd_s_r[1]};
      end
   end

   // ****************************************
   // Mode machine and time-out
   // ****************************************
   mode_t       mode_r;
   logic [16:0] to_cnt_r;
   logic [1:0]  wake_cnt_r, slp_cnt_r;
   logic        slp_pend_r, pa_hold_r, hold_data_r, timeout;
   logic [7:0]  cfg0_r, cfg1_r;
   logic        p0_r, p1_r;
   assign timeout = (to_cnt_r == 17'(TIMEOUT));
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst)
         to_cnt_r <= 17'h0;
      else if (en_rise || tx_cmd)
         to_cnt_r <= 17'h0;
      else if (!en && !timeout)
         to_cnt_r <= to_cnt_r + 17'd1;
   end
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wake_cnt_r <= 2'h0;
      end else if (mode_r != MODE_SLEEP || !en) begin
         wake_cnt_r <= 2'h0;
      end else if (sck_rise && wake_cnt_r != 2'(WAKE_PULSES)) begin
         wake_cnt_r <= wake_cnt_r + 2'd1;
      end
   end
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_r      <= MODE_SLEEP;
         slp_pend_r  <= 1'b0;
         slp_cnt_r   <= 2'h0;
         pa_hold_r   <= 1'b0;
         hold_data_r <= 1'b0;
      end else begin
         if (en_fall && cfg1_r[SLEEP_REQ_BIT] && mode_r != MODE_SLEEP) begin
            slp_pend_r <= 1'b1;
            slp_cnt_r  <= 2'h0;
         end else if (slp_pend_r) begin
            slp_cnt_r <= slp_cnt_r + 2'd1;
         end
         unique case (mode_r)
            MODE_SLEEP:
               if (en && wake_cnt_r == 2'(WAKE_PULSES))
                  mode_r <= MODE_OSC;
            MODE_STANDBY:
               if (en_rise)
                  mode_r <= MODE_OSC;
            MODE_OSC, MODE_PLL, MODE_TX: begin
               if (slp_pend_r && slp_cnt_r == 2'(SLEEP_LAT_CYC - 1)) begin
                  mode_r     <= MODE_SLEEP;
                  slp_pend_r <= 1'b0;
               end else if (tx_cmd) begin
                  mode_r    <= MODE_PLL;
                  pa_hold_r <= sh_r[TX_PA_MODE_BIT - 1];
               end else if (mode_r == MODE_PLL && sck_rise) begin
                  mode_r <= MODE_TX;
               end else if (mode_r == MODE_TX && en_fall && !pa_hold_r) begin
                  mode_r <= MODE_OSC;
               end else if (en_fall && cfg0_r[STBY_REQ_BIT]) begin
                  mode_r <= MODE_STANDBY;
               end else if (!en && timeout) begin
                  mode_r <= MODE_STANDBY;
               end
               if (mode_r == MODE_TX && en_fall && pa_hold_r)
                  hold_data_r <= sd_s_r[1];
            end
            default: mode_r <= MODE_SLEEP;
         endcase
      end
   end
   logic core_rst_i;
   assign core_rst_i = (mode_r == MODE_SLEEP) | bo_s_r[1];

   // ****************************************
   // Configuration registers with parity
   // ****************************************
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg0_r <= CFG0_RESET;
         cfg1_r <= CFG1_RESET;
         p0_r   <= par8(CFG0_RESET);
         p1_r   <= par8(CFG1_RESET);
      end else if (core_rst_i) begin
         cfg0_r <= CFG0_RESET;
         cfg1_r <= CFG1_RESET;
         p0_r   <= par8(CFG0_RESET);
         p1_r   <= par8(CFG1_RESET);
      end else begin
         if (wr_stb && cmd_r[6:0] == CFG0_ADDR) begin
            cfg0_r <= {sh_r[6:0], sd_s_r[1]};
            p0_r   <= par8({sh_r[6:0], sd_s_r[1]});
         end else if (en_fall && cfg0_r[STBY_REQ_BIT]) begin
            cfg0_r[STBY_REQ_BIT] <= 1'b0;
            p0_r <= ~p0_r;
         end
         if (wr_stb && cmd_r[6:0] == CFG1_ADDR) begin
            cfg1_r <= {sh_r[6:0], sd_s_r[1]};
            p1_r   <= par8({sh_r[6:0], sd_s_r[1]});
         end
      end
   end
   // Sleep request clears on wake via register reset

   // ****************************************
   // Status flags
   // ****************************************
   logic brown_r, par_err_r, lock_err_r, lb1_r, lb2_r, st_rd;
   assign st_rd = rd_stb && {sh_r[5:0], sd_s_r[1]} == STATUS_ADDR;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         brown_r    <= 1'b1;
         par_err_r  <= 1'b0;
         lock_err_r <= 1'b0;
      end else begin
         brown_r    <= bo_s_r[1] | (brown_r & ~st_rd);
         par_err_r  <= (par8(cfg0_r) != p0_r) | (par8(cfg1_r) != p1_r)
                       | (par_err_r & ~st_rd);
         lock_err_r <= (mode_r == MODE_TX && !lk_s_r[1])
                       | (lock_err_r & ~st_rd);
      end
   end
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lb1_r <= 1'b0;
         lb2_r <= 1'b0;
      end else if (mode_r == MODE_PLL && sck_rise) begin
         lb1_r <= 1'b0;
         lb2_r <= 1'b0;
      end else begin
         lb1_r <= lb1_r | b1_s_r[1];
         lb2_r <= lb2_r | (lb1_r & b2_s_r[1]);
      end
   end
   logic [7:0] status;
   always_comb begin
      status               = 8'h00;
      status[ST_ONE_BIT]   = 1'b1;
      status[ST_LB2_BIT]   = lb2_r & (mode_r != MODE_STANDBY);
      status[ST_LB1_BIT]   = lb1_r & (mode_r != MODE_STANDBY);
      status[ST_BROWN_BIT] = brown_r;
      status[ST_PAR_BIT]   = par_err_r;
      status[ST_LOCK_BIT]  = lock_err_r;
   end

   // ****************************************
   // Read data shift-out on falling clock
   // ****************************************
   logic       rd_act_r;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_r     <= 8'h0;
         rd_act_r <= 1'b0;
      end else if (!en) begin
         rd_act_r <= 1'b0;
      end else if (rd_stb) begin
         rd_act_r <= 1'b1;
         unique case ({sh_r[5:0], sd_s_r[1]})
            STATUS_ADDR: rd_r <= status;
            CFG0_ADDR:   rd_r <= cfg0_r;
            CFG1_ADDR:   rd_r <= cfg1_r;
            default:     rd_r <= 8'h00;
         endcase
      end else if (rd_act_r && sck_fall && bit_cnt_r != 5'd8) begin
         rd_r <= {rd_r[6:0], 1'b0};
      end
   end
   assign lnk.sdio_d    = rd_r[7];
   assign lnk.sdio_d_oe = rd_act_r;

   // ****************************************
   // Outputs
   // ****************************************
   logic pa_ok;
   assign pa_ok = cfg0_r[FS_DIS_BIT] | ~(brown_r | par_err_r | lock_err_r);
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pa_on    <= 1'b0;
         pll_on   <= 1'b0;
         osc_on   <= 1'b0;
         tx_data  <= 1'b0;
         core_rst <= 1'b1;
      end else begin
         pa_on    <= (mode_r == MODE_TX) & pa_ok;
         pll_on   <= (mode_r == MODE_TX) | (mode_r == MODE_PLL);
         osc_on   <= (mode_r != MODE_SLEEP) & (mode_r != MODE_STANDBY);
         tx_data  <= (!en && pa_hold_r) ? hold_data_r : sd_s_r[1];
         core_rst <= core_rst_i;
      end
   end
   assign mode = mode_r;
endmodule

// >>> core/tx_link_host.sv
`timescale 1ns/1ps
module tx_link_host
   import txpm_pkg::*;
#(
   parameter int HALF = 4
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   // Link
   txpm_if.host             lnk,
   // AXI4-Lite write
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   // ****************************************
   // Command register: [15:0] frame, [16] read, [17] keep enable
   // ****************************************
   logic [3:0]  aw_r;
   logic        aw_ok_r, w_ok_r, busy_r, rdf_r, keep_r;
   logic [31:0] wd_r;
   logic [15:0] sh_r;
   logic [7:0]  rx_r;
   logic [4:0]  bits_r;
   logic [7:0]  div_r;
   logic        sdi_s0_r, sdi_s1_r;
   assign s_axi_awready = ~aw_ok_r & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_ok_r & ~s_axi_bvalid;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         aw_ok_r      <= 1'b0;
         w_ok_r       <= 1'b0;
         aw_r         <= 4'h0;
         wd_r         <= 32'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= AXI_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ok_r <= 1'b1;
            aw_r    <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ok_r <= 1'b1;
            wd_r   <= s_axi_wdata;
         end
         if (aw_ok_r && w_ok_r) begin
            aw_ok_r      <= 1'b0;
            w_ok_r       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_r == H_CMD_OFS && !busy_r) ? AXI_OKAY
                                                          : AXI_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   logic start;
   assign start = aw_ok_r & w_ok_r & (aw_r == H_CMD_OFS) & ~busy_r;

   // ****************************************
   // Serial engine
   // ****************************************
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sdi_s0_r <= 1'b0;
         sdi_s1_r <= 1'b0;
      end else begin
         sdi_s0_r <= lnk.sdio;
         sdi_s1_r <= sdi_s0_r;
      end
   end
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         busy_r   <= 1'b0;
         rdf_r    <= 1'b0;
         keep_r   <= 1'b0;
         sh_r     <= 16'h0;
         rx_r     <= 8'h0;
         bits_r   <= 5'h0;
         div_r    <= 8'h0;
         lnk.en   <= 1'b0;
         lnk.sclk <= 1'b0;
      end else if (start) begin
         busy_r   <= 1'b1;
         rdf_r    <= wd_r[16];
         keep_r   <= wd_r[17];
         sh_r     <= wd_r[15:0];
         bits_r   <= 5'h0;
         div_r    <= 8'h0;
         lnk.en   <= 1'b1;
         lnk.sclk <= 1'b0;
      end else if (busy_r) begin
         if (div_r == 8'(HALF - 1)) begin
            div_r <= 8'h0;
            if (bits_r == 5'd16) begin
               busy_r <= 1'b0;
               lnk.en <= keep_r;
            end else if (!lnk.sclk) begin
               lnk.sclk <= 1'b1;
            end else begin
               // Sample late: read data trails the falling edge
               lnk.sclk <= 1'b0;
               rx_r     <= {rx_r[6:0], sdi_s1_r};
               sh_r     <= {sh_r[14:0], 1'b0};
               bits_r   <= bits_r + 5'd1;
            end
         end else begin
            div_r <= div_r + 8'd1;
         end
      end
   end
   assign lnk.sdio_h    = sh_r[15];
   assign lnk.sdio_h_oe = busy_r & ~(rdf_r & bits_r[3]);

   // ****************************************
   // Read side
   // ****************************************
   assign s_axi_arready = ~s_axi_rvalid;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= AXI_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= AXI_OKAY;
         unique case (s_axi_araddr)
            H_CMD_OFS:   s_axi_rdata <= {14'h0, keep_r, rdf_r, sh_r};
            H_STAT_OFS:  s_axi_rdata <= {30'h0, lnk.en, busy_r};
            H_RDATA_OFS: s_axi_rdata <= {24'h0, rx_r};
            default: begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= AXI_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// >>> sim/txpm_sva.sv
`timescale 1ns/1ps
module txpm_sva
   import txpm_pkg::*;
(
   // Clock and reset
   input wire logic  sys_clk,
   input wire logic  sys_rst,
   // Link and state
   input wire logic  en,
   input wire mode_t mode,
   input wire logic  pa_on,
   input wire logic  pll_on,
   input wire logic  osc_on
);
   // ****************
   // Mode steps
   // ****************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_enter_pll;
      $changed(mode) && mode == MODE_PLL;
   endsequence
   sequence s_enter_tx;
      $changed(mode) && mode == MODE_TX;
   endsequence
   sequence s_enter_sleep;
      $changed(mode) && mode == MODE_SLEEP;
   endsequence
   sequence s_leave_low;
      $changed(mode) && $past(mode) inside {MODE_SLEEP, MODE_STANDBY};
   endsequence
   sequence s_leave_osc;
      $changed(mode) && $past(mode) == MODE_OSC;
   endsequence

   // ****************
   // Checks
   // ****************
   a_pa_only_tx: assert property (
      pa_on |-> mode == MODE_TX || $past(mode) == MODE_TX)
      else $error("amplifier on outside transmit");
   a_pll_no_pa: assert property (
      mode == MODE_PLL && $past(mode) == MODE_PLL |-> !pa_on)
      else $error("amplifier on in pll state");
   a_tx_via_pll: assert property (
      s_enter_tx |-> $past(mode) == MODE_PLL)
      else $error("transmit entered without pll state");
   a_pll_starts: assert property (
      s_enter_pll |-> ##[0:2] pll_on)
      else $error("pll not started");
   a_wake_to_osc: assert property (
      s_leave_low |-> mode == MODE_OSC)
      else $error("low mode left to wrong state");
   a_osc_quiet: assert property (
      mode == MODE_OSC && $past(mode) == MODE_OSC
      |-> osc_on && !pll_on && !pa_on)
      else $error("oscillator state outputs wrong");
   a_sleep_en_low: assert property (
      s_enter_sleep |-> !$past(en))
      else $error("sleep entered with enable high");
   a_osc_exit: assert property (
      s_leave_osc
      |-> mode inside {MODE_SLEEP, MODE_STANDBY, MODE_PLL})
      else $error("oscillator state left wrongly");
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) \
   begin \
      tests_run++; \
      if ((a) !== (b)) begin \
         n_fail++; \
         $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); \
      end \
   end
module tb_top
   import txpm_pkg::*;
;
   // ****************
   // Signals
   // ****************
   typedef struct packed {
      logic [31:0] w;
      logic        chk;
      logic [7:0]  exp;
   } row_t;
   logic        sys_clk = 1'h0;
   logic        sys_rst = 1'h1;
   logic        brownout_in = 1'h0, pll_locked = 1'h1;
   logic        batt_below_first = 1'h0, batt_below_second = 1'h0;
   logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic        s_axi_arvalid = 1'h0;
   logic        s_axi_bready = 1'h1, s_axi_rready = 1'h1;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_rdata, d;
   logic        pa_on, pll_on, osc_on, tx_data, core_rst;
   mode_t       mode;
   logic [7:0]  q;
   int          n_fail = 0, tests_run = 0;
   row_t        rows [7] = '{
      '{32'h00018400, 1'h0, 8'h00}, // Wake
      '{32'h00018100, 1'h1, 8'h84},
      '{32'h00018100, 1'h1, 8'h80},
      '{32'h00018400, 1'h1, 8'h06},
      '{32'h00018500, 1'h1, 8'h25},
      '{32'h00000535, 1'h0, 8'h00},
      '{32'h00018500, 1'h1, 8'h35}};

   txpm_if lnk ();
   tx_power_mode_failsafe_ctrl #(.TIMEOUT(64))
      tx_power_mode_failsafe_ctrl_i (
      .sys_clk, .sys_rst, .lnk, .brownout_in, .batt_below_first,
      .batt_below_second, .pll_locked, .mode, .pa_on, .pll_on, .osc_on,
      .tx_data, .core_rst);
   tx_link_host #(.HALF(4)) tx_link_host_i (
      .sys_clk, .sys_rst, .lnk, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   txpm_sva txpm_sva_i (
      .sys_clk, .sys_rst, .en(lnk.en), .mode, .pa_on, .pll_on, .osc_on);

   always #20 sys_clk = ~sys_clk;

   // ****************
   // Tasks
   // ****************
   task automatic close_out;
      if (n_fail == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic bail;
      n_fail++;
      close_out();
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   task automatic axw(input logic [3:0] a, input logic [31:0] v,
                      output logic [1:0] rs);
      int   n;
      logic ta, tw, tb;
      n = 0;
      tb = 1'h0;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      while (!tb && n < 100) begin
         @(negedge sys_clk);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         tb = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge sys_clk);
         if (ta) s_axi_awvalid <= 1'h0;
         if (tw) s_axi_wvalid <= 1'h0;
         n++;
      end
      if (!tb) bail();
   endtask
   task automatic axr(input logic [3:0] a, output logic [31:0] v,
                      output logic [1:0] rs);
      int   n;
      logic ta, tr;
      n = 0;
      tr = 1'h0;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      while (!tr && n < 100) begin
         @(negedge sys_clk);
         ta = s_axi_arvalid & s_axi_arready;
         tr = s_axi_rvalid;
         v = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge sys_clk);
         if (ta) s_axi_arvalid <= 1'h0;
         n++;
      end
      if (!tr) bail();
   endtask
   task automatic frame(input logic [31:0] w, output logic [7:0] b);
      logic [31:0] v;
      logic [1:0]  rs;
      int          n;
      axw(H_CMD_OFS, w, rs);
      `CHK(rs, AXI_OKAY);
      v = 32'h1;
      n = 0;
      while (v[0] && n < 200) begin
         axr(H_STAT_OFS, v, rs);
         n++;
      end
      if (v[0]) bail();
      axr(H_RDATA_OFS, v, rs);
      b = v[7:0];
      @(negedge sys_clk);
   endtask

   // ****************
   // Sequence
   // ****************
   initial begin
      repeat (3) @(posedge sys_clk);
      sys_rst <= 1'h0;
      foreach (rows[i]) begin
         frame(rows[i].w, q);
         if (rows[i].chk)
            `CHK(q, rows[i].exp);
      end
      cyc(20);
      `CHK(mode, MODE_OSC);
      cyc(50);
      `CHK(mode, MODE_STANDBY);
      frame(32'h00018500, q);
      `CHK(q, 8'h35);
      `CHK(mode, MODE_OSC);
      frame(32'h00000486, q);
      cyc(10);
      `CHK(mode, MODE_STANDBY);
      frame(32'h00018400, q);
      `CHK(q, 8'h06);
      frame(32'h0000d000, q);
      cyc(5);
      `CHK(mode, MODE_TX);
      `CHK(tx_data, 1'h0);
      `CHK(pa_on, 1'h1);
      @(posedge sys_clk);
      pll_locked <= 1'h0;
      cyc(10);
      `CHK(pa_on, 1'h0);
      @(posedge sys_clk);
      pll_locked <= 1'h1;
      cyc(80);
      `CHK(mode, MODE_STANDBY);
      frame(32'h00018100, q);
      `CHK(q, 8'h81);
      frame(32'h0000c000, q);
      cyc(10);
      `CHK(mode, MODE_OSC);
      `CHK(pa_on, 1'h0);
      frame(32'h00000416, q);
      frame(32'h0000d000, q);
      @(posedge sys_clk);
      pll_locked <= 1'h0;
      cyc(10);
      `CHK(pa_on, 1'h1);
      @(posedge sys_clk);
      pll_locked <= 1'h1;
      batt_below_first <= 1'h1;
      batt_below_second <= 1'h1;
      frame(32'h00018100, q);
      `CHK(q, 8'hb1);
      @(posedge sys_clk);
      batt_below_first <= 1'h0;
      batt_below_second <= 1'h0;
      frame(32'h0000c000, q);
      frame(32'h00018100, q);
      `CHK(q, 8'h80);
      frame(32'h000005b5, q);
      cyc(10);
      `CHK(mode, MODE_SLEEP);
      frame(32'h00018500, q);
      `CHK(q, 8'h25);
      `CHK(mode, MODE_OSC);
      @(posedge sys_clk);
      brownout_in <= 1'h1;
      cyc(5);
      `CHK(core_rst, 1'h1);
      @(posedge sys_clk);
      brownout_in <= 1'h0;
      cyc(5);
      frame(32'h00018100, q);
      `CHK(q, 8'h84);
      axr(4'hc, d, r);
      `CHK({r, d}, {AXI_SLVERR, 32'h0});
      axw(4'h4, 32'h0, r);
      `CHK(r, AXI_SLVERR);
      close_out();
   end
endmodule
